// *** common/iorac_pkg.sv ***
// Overview of operation
// - read io: instruction 15, type=port, bank 0/1/2
// - digital reads return only 0 or 1
// - program read loads value into accumulator
// - direct read replies only, accumulator untouched
// - direct read answers status 100 with state
// - bank 0: ref right, ref left, input0, enable
// - bank 1: four analog samples 0 to 4095
// - analog lines readable as analog only, in bank 1
// - bank 2 reads back driven output state
// - arith: instruction 19, type=op, value=operand
// - op codes 0..9: add through load
// - direct arith replies 100, echoes operand
// - compare: instruction 20, type/bank ignored
// - compare updates flags for conditional jump
// - command frame: addr,instr,type,bank,value msb,checksum
// - reply: host,target,status,instr,value,checksum; 64h ok
// - value field is signed 32-bit two's complement
// - set output drives line to value bit
package iorac_pkg;

    // ****************************************
    // frame layout
    // ****************************************
    localparam int FRAME_LEN = 9;
    localparam logic [3:0] FRAME_LAST = 4'h8;
    localparam int IDX_ADDR = 0;
    localparam int IDX_INSTR = 1;
    localparam int IDX_TYPE = 2;
    localparam int IDX_BANK = 3;
    localparam int IDX_VALUE = 4;
    localparam int IDX_CSUM = 8;
    localparam int IDX_R_HOST = 0;
    localparam int IDX_R_TARGET = 1;
    localparam int IDX_R_STATUS = 2;
    localparam int IDX_R_INSTR = 3;

    typedef logic [FRAME_LEN-1:0][7:0] iorac_frame_type;

    // ****************************************
    // instructions and status
    // ****************************************
    localparam logic [7:0] INSTR_SET_OUTPUT = 8'h0E;
    localparam logic [7:0] INSTR_READ_IO = 8'h0F;
    localparam logic [7:0] INSTR_ARITH = 8'h13;
    localparam logic [7:0] INSTR_COMPARE = 8'h14;
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;

    localparam logic [7:0] BANK_DIGITAL = 8'h00;
    localparam logic [7:0] BANK_ANALOG = 8'h01;
    localparam logic [7:0] BANK_OUTPUTS = 8'h02;
    localparam logic [7:0] PORT_COUNT_IN = 8'h04;
    localparam logic [7:0] PORT_COUNT_OUT = 8'h01;

    typedef enum logic [7:0] {
        OP_ADD = 8'h00, OP_SUB = 8'h01, OP_MUL = 8'h02, OP_DIV = 8'h03, OP_MOD = 8'h04,
        OP_AND = 8'h05, OP_OR = 8'h06, OP_XOR = 8'h07, OP_NOT = 8'h08, OP_LOAD = 8'h09
    } iorac_op_type;

    // ****************************************
    // reset values
    // ****************************************
    localparam int ADC_WIDTH = 12;
    localparam logic [31:0] ACC_RESET = 32'h0000_0000;
    localparam logic OUT_RESET = 1'b0;

    // byte sum of the eight bytes ahead of the checksum
    function automatic logic [7:0] frame_sum(input iorac_frame_type f);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < IDX_CSUM; i++) begin
            s = s + f[i];
        end
        return s;
    endfunction : frame_sum

endpackage : iorac_pkg

// *** hw/iorac_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
module iorac_alu
    import iorac_pkg::*;
(
    // operands
    input wire logic [31:0] acc,
    input wire logic [31:0] operand,
    input wire logic [7:0] op,
    // result
    output logic [31:0] result,
    output logic op_ok
);

    // ****************************************
    // arithmetic
    // ****************************************
    // divide by zero keeps the accumulator rather than inventing a value
    always_comb begin
        result = acc;
        op_ok = 1'b1;
        unique case (op)
            OP_ADD: result = acc + operand;
            OP_SUB: result = acc - operand;
            OP_MUL: result = 32'($signed(acc) * $signed(operand));
            OP_DIV: if (operand != 32'h0000_0000) result = 32'($signed(acc) / $signed(operand));
            OP_MOD: if (operand != 32'h0000_0000) result = 32'($signed(acc) % $signed(operand));
            OP_AND: result = acc & operand;
            OP_OR: result = acc | operand;
            OP_XOR: result = acc ^ operand;
            OP_NOT: result = ~acc;
            OP_LOAD: result = operand;
            default: op_ok = 1'b0;
        endcase
    end

endmodule : iorac_alu
`default_nettype wire

// *** hw/iorac_port_read.sv ***
`timescale 1ns/1ps
`default_nettype none
module iorac_port_read
    import iorac_pkg::*;
#(
    parameter int ADC_W = ADC_WIDTH
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pins, asynchronous
    input wire logic ref_right_pin,
    input wire logic ref_left_pin,
    input wire logic gp_in0_pin,
    input wire logic enable_pin,
    // samples from converter logic, same clock
    input wire logic [ADC_W-1:0] phase_a_current_sample,
    input wire logic [ADC_W-1:0] phase_c_current_sample,
    input wire logic [ADC_W-1:0] supply_voltage_sample,
    input wire logic [ADC_W-1:0] motor_temperature_sample,
    // driven output state
    input wire logic general_output_zero,
    // selection and result
    input wire logic [7:0] bank,
    input wire logic [7:0] port,
    output logic [31:0] rd_value,
    output logic rd_ok
);

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [3:0] sync1;
    logic [3:0] sync2;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= {enable_pin, gp_in0_pin, ref_left_pin, ref_right_pin};
            sync2 <= sync1;
        end
    end

    // ****************************************
    // bank and port select
    // ****************************************
    // digital and analog paths are independent, so neither blocks the other
    always_comb begin
        rd_value = 32'h0000_0000;
        rd_ok = 1'b0;
        if (bank == BANK_DIGITAL && port < PORT_COUNT_IN) begin
            rd_value = {31'h0000_0000, sync2[port[1:0]]};
            rd_ok = 1'b1;
        end else if (bank == BANK_ANALOG && port < PORT_COUNT_IN) begin
            rd_ok = 1'b1;
            unique case (port[1:0])
                2'h0: rd_value = 32'(phase_a_current_sample);
                2'h1: rd_value = 32'(phase_c_current_sample);
                2'h2: rd_value = 32'(supply_voltage_sample);
                2'h3: rd_value = 32'(motor_temperature_sample);
            endcase
        end else if (bank == BANK_OUTPUTS && port < PORT_COUNT_OUT) begin
            rd_value = {31'h0000_0000, general_output_zero};
            rd_ok = 1'b1;
        end
    end

endmodule : iorac_port_read
`default_nettype wire

// *** hw/iorac_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module iorac_top
    import iorac_pkg::*;
#(
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter logic [7:0] HOST_ADDR = 8'h02
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // command bytes in
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    output logic rx_ready,
    // reply bytes out
    output logic [7:0] tx_byte,
    output logic tx_valid,
    input wire logic tx_ready,
    // program memory instruction port
    input wire logic prog_valid,
    input wire logic [7:0] prog_instr,
    input wire logic [7:0] prog_type,
    input wire logic [7:0] prog_bank,
    input wire logic [31:0] prog_value,
    output logic prog_ready,
    output logic prog_error,
    // pins and samples
    input wire logic ref_right_pin,
    input wire logic ref_left_pin,
    input wire logic gp_in0_pin,
    input wire logic enable_pin,
    input wire logic [ADC_WIDTH-1:0] phase_a_current_sample,
    input wire logic [ADC_WIDTH-1:0] phase_c_current_sample,
    input wire logic [ADC_WIDTH-1:0] supply_voltage_sample,
    input wire logic [ADC_WIDTH-1:0] motor_temperature_sample,
    // state out
    output logic general_output_zero,
    output logic [31:0] accumulator,
    output logic flag_zero,
    output logic flag_greater,
    output logic flag_less
);

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {
        ST_RECV = 3'b001,
        ST_EXEC = 3'b010,
        ST_SEND = 3'b100
    } iorac_state_type;

    iorac_state_type state, next_state;
    logic [3:0] rx_count, next_rx_count;
    logic [3:0] tx_count, next_tx_count;
    iorac_frame_type frame, next_frame;
    iorac_frame_type reply, next_reply;
    logic [31:0] acc, next_acc;
    logic fz, next_fz;
    logic fg, next_fg;
    logic fl, next_fl;
    logic out0, next_out0;
    logic perr, next_perr;

    logic exec_fire;
    logic prog_fire;
    logic rx_csum_ok;
    logic [7:0] sel_instr;
    logic [7:0] sel_type;
    logic [7:0] sel_bank;
    logic [31:0] sel_value;
    logic [31:0] rd_value;
    logic rd_ok;
    logic [31:0] alu_result;
    logic alu_ok;

    // ****************************************
    // handshakes and selection
    // ****************************************
    assign rx_ready = (state == ST_RECV);
    assign tx_valid = (state == ST_SEND);
    assign tx_byte = reply[tx_count];
    // program port waits only while a direct frame executes
    assign prog_ready = (state != ST_EXEC);
    assign exec_fire = (state == ST_EXEC);
    assign prog_fire = prog_valid && prog_ready;
    assign rx_csum_ok = (frame_sum(frame) == rx_byte) && (frame[IDX_ADDR] == MODULE_ADDR);

    assign sel_instr = exec_fire ? frame[IDX_INSTR] : prog_instr;
    assign sel_type = exec_fire ? frame[IDX_TYPE] : prog_type;
    assign sel_bank = exec_fire ? frame[IDX_BANK] : prog_bank;
    assign sel_value = exec_fire ? {frame[4], frame[5], frame[6], frame[7]} : prog_value;

    assign accumulator = acc;
    assign flag_zero = fz;
    assign flag_greater = fg;
    assign flag_less = fl;
    assign general_output_zero = out0;
    assign prog_error = perr;

    iorac_port_read u_port_read (
        .sys_clk(sys_clk),
        .rst(rst),
        .ref_right_pin(ref_right_pin),
        .ref_left_pin(ref_left_pin),
        .gp_in0_pin(gp_in0_pin),
        .enable_pin(enable_pin),
        .phase_a_current_sample(phase_a_current_sample),
        .phase_c_current_sample(phase_c_current_sample),
        .supply_voltage_sample(supply_voltage_sample),
        .motor_temperature_sample(motor_temperature_sample),
        .general_output_zero(out0),
        .bank(sel_bank),
        .port(sel_type),
        .rd_value(rd_value),
        .rd_ok(rd_ok)
    );

    iorac_alu u_alu (
        .acc(acc),
        .operand(sel_value),
        .op(sel_type),
        .result(alu_result),
        .op_ok(alu_ok)
    );

    // ****************************************
    // frame and execute logic
    // ****************************************
    always_comb begin
        logic [7:0] status;
        logic [31:0] rvalue;
        logic ok;
        status = STATUS_OK;
        rvalue = 32'h0000_0000;
        ok = 1'b1;
        next_state = state;
        next_rx_count = rx_count;
        next_tx_count = tx_count;
        next_frame = frame;
        next_reply = reply;
        next_acc = acc;
        next_fz = fz;
        next_fg = fg;
        next_fl = fl;
        next_out0 = out0;
        next_perr = perr;

        // shared execution of the selected instruction
        unique case (sel_instr)
            INSTR_READ_IO: begin
                ok = rd_ok;
                rvalue = rd_value;
            end
            INSTR_ARITH: begin
                ok = alu_ok;
                rvalue = sel_value;
            end
            INSTR_COMPARE: rvalue = sel_value;
            INSTR_SET_OUTPUT: ok = (sel_bank == BANK_OUTPUTS) && (sel_type < PORT_COUNT_OUT);
            default: ok = 1'b0;
        endcase
        if (!ok) begin
            rvalue = 32'h0000_0000;
        end

        if (exec_fire || prog_fire) begin
            if (ok && sel_instr == INSTR_ARITH) begin
                next_acc = alu_result;
            end
            if (ok && sel_instr == INSTR_READ_IO && prog_fire) begin
                next_acc = rd_value;
            end
            if (sel_instr == INSTR_COMPARE) begin
                next_fz = (acc == sel_value);
                next_fg = ($signed(acc) > $signed(sel_value));
                next_fl = ($signed(acc) < $signed(sel_value));
            end
            if (ok && sel_instr == INSTR_SET_OUTPUT) begin
                next_out0 = sel_value[0];
            end
        end

        if (prog_fire) begin
            next_perr = !ok;
        end

        unique case (state)
            ST_RECV: begin
                if (rx_valid) begin
                    next_frame[rx_count] = rx_byte;
                    if (rx_count == FRAME_LAST) begin
                        next_rx_count = 4'h0;
                        if (rx_csum_ok) begin
                            next_state = ST_EXEC;
                        end
                    end else begin
                        next_rx_count = rx_count + 4'h1;
                    end
                end
            end
            ST_EXEC: begin
                if (sel_instr != INSTR_READ_IO && sel_instr != INSTR_ARITH && sel_instr != INSTR_COMPARE
                        && sel_instr != INSTR_SET_OUTPUT) begin
                    status = STATUS_BAD_CMD;
                end else if (!ok) begin
                    status = STATUS_BAD_VALUE;
                end
                next_reply[IDX_R_HOST] = HOST_ADDR;
                next_reply[IDX_R_TARGET] = MODULE_ADDR;
                next_reply[IDX_R_STATUS] = status;
                next_reply[IDX_R_INSTR] = sel_instr;
                next_reply[4] = rvalue[31:24];
                next_reply[5] = rvalue[23:16];
                next_reply[6] = rvalue[15:8];
                next_reply[7] = rvalue[7:0];
                next_reply[IDX_CSUM] = frame_sum(next_reply);
                next_tx_count = 4'h0;
                next_state = ST_SEND;
            end
            ST_SEND: begin
                if (tx_ready) begin
                    if (tx_count == FRAME_LAST) begin
                        next_state = ST_RECV;
                    end else begin
                        next_tx_count = tx_count + 4'h1;
                    end
                end
            end
            default: next_state = ST_RECV;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_RECV;
            rx_count <= 4'h0;
            tx_count <= 4'h0;
            frame <= '0;
            reply <= '0;
            acc <= ACC_RESET;
            fz <= 1'b0;
            fg <= 1'b0;
            fl <= 1'b0;
            out0 <= OUT_RESET;
            perr <= 1'b0;
        end else begin
            state <= next_state;
            rx_count <= next_rx_count;
            tx_count <= next_tx_count;
            frame <= next_frame;
            reply <= next_reply;
            acc <= next_acc;
            fz <= next_fz;
            fg <= next_fg;
            fl <= next_fl;
            out0 <= next_out0;
            perr <= next_perr;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    digital_zero_one_a: assert property (rd_ok && sel_bank == BANK_DIGITAL |-> rd_value <= 32'h0000_0001)
        else $error("digital read outside 0/1");
    analog_range_a: assert property (rd_ok && sel_bank == BANK_ANALOG |-> rd_value <= 32'h0000_0FFF)
        else $error("analog read above 4095");
    direct_read_keeps_a: assert property (exec_fire && sel_instr == INSTR_READ_IO |=> $stable(acc))
        else $error("direct read changed accumulator");
    prog_read_loads_a: assert property (prog_fire && sel_instr == INSTR_READ_IO && rd_ok |=> acc == $past(rd_value))
        else $error("program read did not load accumulator");
    read_reply_ok_a: assert property (exec_fire && sel_instr == INSTR_READ_IO && rd_ok
        |=> reply[IDX_R_STATUS] == STATUS_OK && {reply[4], reply[5], reply[6], reply[7]} == $past(rd_value))
        else $error("read reply wrong");
    arith_echo_a: assert property (exec_fire && sel_instr == INSTR_ARITH && alu_ok
        |=> {reply[4], reply[5], reply[6], reply[7]} == $past(sel_value) && acc == $past(alu_result))
        else $error("arith reply or result wrong");
    compare_flags_a: assert property (prog_fire && sel_instr == INSTR_COMPARE
        |=> fz == ($past(acc) == $past(sel_value)) && fl == ($signed($past(acc)) < $signed($past(sel_value))))
        else $error("compare flags wrong");
    output_set_a: assert property ((exec_fire || prog_fire) && sel_instr == INSTR_SET_OUTPUT && sel_bank == BANK_OUTPUTS
        && sel_type == 8'h00 |=> out0 == $past(sel_value[0]))
        else $error("output not driven");
    reply_checksum_a: assert property (tx_valid |-> reply[IDX_CSUM] == frame_sum(reply)
        && reply[IDX_R_STATUS] != 8'h00)
        else $error("reply checksum wrong");
    bad_frame_drop_a: assert property (rx_ready && rx_valid && rx_count == FRAME_LAST && !rx_csum_ok
        |=> state == ST_RECV [*2])
        else $error("bad frame executed");
    exec_to_send_a: assert property (exec_fire |=> tx_valid && tx_count == 4'h0 && tx_byte == HOST_ADDR)
        else $error("reply did not start");

    // eight repeats plus the closing byte keep the unrolled sequence short
    read_frame_c: cover property (exec_fire && sel_instr == INSTR_READ_IO ##1 tx_valid [*8]
        ##1 tx_valid && tx_count == FRAME_LAST);
    prog_arith_c: cover property (prog_fire && sel_instr == INSTR_ARITH);
    compare_c: cover property (prog_fire && sel_instr == INSTR_COMPARE ##1 fg);
    bad_csum_c: cover property (rx_valid && rx_count == FRAME_LAST && !rx_csum_ok);

endmodule : iorac_top
`default_nettype wire

// *** verification/iorac_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module iorac_host_model
    import iorac_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // command bytes
    output logic [7:0] rx_byte,
    output logic rx_valid,
    input wire logic rx_ready,
    // reply bytes
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    output logic tx_ready
);
    initial begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end

    // ****
    // frame out, whole and in order
    // ****
    task automatic send(input iorac_frame_type f);
        logic ok;
        for (int i = 0; i < FRAME_LEN; i++) begin
            rx_byte <= f[i];
            rx_valid <= 1'b1;
            do begin
                @(negedge sys_clk);
                ok = rx_ready;
                @(posedge sys_clk);
            end while (!ok);
        end
        rx_valid <= 1'b0;
        // released line shows the inverse, never a stale byte
        rx_byte <= ~f[IDX_CSUM];
    endtask : send

    // ****
    // reply in, slow mode stalls each byte
    // ****
    task automatic recv(input logic slow, output iorac_frame_type r);
        logic ok;
        logic [7:0] b;
        r = '0;
        for (int i = 0; i < FRAME_LEN; i++) begin
            if (slow) begin
                tx_ready <= 1'b0;
                @(posedge sys_clk);
            end
            tx_ready <= 1'b1;
            do begin
                @(negedge sys_clk);
                ok = tx_valid & tx_ready;
                b = tx_byte;
                @(posedge sys_clk);
            end while (!ok);
            r[i] = b;
        end
        tx_ready <= 1'b0;
    endtask : recv
endmodule : iorac_host_model
`default_nettype wire

// *** verification/io_read_accumulator_cmds_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module io_read_accumulator_cmds_tb
    import iorac_pkg::*;
;
    logic sys_clk, rst, rx_valid, rx_ready, tx_valid, tx_ready, prog_valid, prog_ready, prog_error;
    logic [7:0] rx_byte, tx_byte, prog_instr, prog_type, prog_bank;
    logic [31:0] prog_value, accumulator, exp_acc;
    logic [3:0] pins;
    logic [11:0] smp [4];
    logic general_output_zero, flag_zero, flag_greater, flag_less;
    int err_total, checks;
    logic [7:0] op_tab [13] = '{8'h09, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
        8'h0A, 8'h09, 8'h00};
    logic [31:0] val_tab [13] = '{32'hFFFFFFF9, 32'h14, 32'h32, 32'hFFFFEC78, 32'hFFFFFFF9, 32'h3E8,
        32'hFF, 32'hF000, 32'hFFFFFFFF, 32'h0, 32'h5, 32'h7FFFFFFF, 32'h1};
    logic [31:0] cmp_val [4] = '{32'h3E8, 32'h3E7, 32'hFFFFF830, 32'h3E9};
    logic [2:0] cmp_exp [4] = '{3'b100, 3'b010, 3'b010, 3'b001};

    iorac_top iorac_top_i (.sys_clk(sys_clk), .rst(rst), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .prog_valid(prog_valid), .prog_instr(prog_instr), .prog_type(prog_type), .prog_bank(prog_bank),
        .prog_value(prog_value), .prog_ready(prog_ready), .prog_error(prog_error),
        .ref_right_pin(pins[0]), .ref_left_pin(pins[1]), .gp_in0_pin(pins[2]), .enable_pin(pins[3]),
        .phase_a_current_sample(smp[0]), .phase_c_current_sample(smp[1]),
        .supply_voltage_sample(smp[2]), .motor_temperature_sample(smp[3]),
        .general_output_zero(general_output_zero), .accumulator(accumulator),
        .flag_zero(flag_zero), .flag_greater(flag_greater), .flag_less(flag_less));

    iorac_host_model iorac_host_model_i (.sys_clk(sys_clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));

    // ****
    // helpers
    // ****
    function automatic logic [7:0] csum(input iorac_frame_type f);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 8; i++) s += f[i];
        return s;
    endfunction : csum

    function automatic logic [31:0] alu(input logic signed [31:0] a, b, input logic [7:0] op);
        case (op)
            8'h00: return a + b;
            8'h01: return a - b;
            8'h02: return a * b;
            8'h03: return (b == 0) ? a : a / b;
            8'h04: return (b == 0) ? a : a % b;
            8'h05: return a & b;
            8'h06: return a | b;
            8'h07: return a ^ b;
            8'h08: return ~a;
            8'h09: return b;
            default: return a;
        endcase
    endfunction : alu

    task automatic check(input logic [31:0] got, exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic prog(input logic [7:0] ins, typ, bnk, input logic [31:0] v);
        logic ok;
        prog_instr <= ins;
        prog_type <= typ;
        prog_bank <= bnk;
        prog_value <= v;
        prog_valid <= 1'b1;
        do begin
            @(negedge sys_clk);
            ok = prog_ready;
            @(posedge sys_clk);
        end while (!ok);
        prog_valid <= 1'b0;
        @(posedge sys_clk);
    endtask : prog

    // mode 0 prompt, 1 stalling host, 2 corrupted checksum
    task automatic cmd(input logic [7:0] adr, ins, typ, bnk, input logic [31:0] v, input int mode,
        input logic [7:0] est, input logic [31:0] ev);
        iorac_frame_type f, r, e;
        f = '0;
        e = '0;
        f[0] = adr;
        f[1] = ins;
        f[2] = typ;
        f[3] = bnk;
        {f[4], f[5], f[6], f[7]} = v;
        f[8] = csum(f) ^ {7'h00, mode == 2};
        iorac_host_model_i.send(f);
        if (adr != 8'h01 || mode == 2) begin
            repeat (12) begin
                @(negedge sys_clk);
                check({31'h0, tx_valid}, 32'h0, "dropped frame answered");
            end
            @(posedge sys_clk);
        end else begin
            iorac_host_model_i.recv(mode == 1, r);
            e[0] = 8'h02;
            e[1] = 8'h01;
            e[2] = est;
            e[3] = ins;
            {e[4], e[5], e[6], e[7]} = ev;
            e[8] = csum(e);
            checks++;
            if (r !== e) begin
                err_total++;
                $display("[FAIL] %0t reply %h exp %h", $time, r, e);
            end
        end
    endtask : cmd

    task automatic conclude();
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    // ****
    // sequence
    // ****
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        {prog_valid, prog_instr, prog_type, prog_bank, prog_value} = '0;
        pins = 4'b0000;
        smp = '{12'h12E, 12'hFFF, 12'h000, 12'hA5C};
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        pins <= 4'b1001;
        @(posedge sys_clk);
        check({accumulator[3:0], flag_zero, flag_greater, flag_less, general_output_zero, prog_error},
            9'h0, "reset state");
        // program port, chosen because compare and arith belong to programs
        exp_acc = 32'h0;
        for (int i = 0; i < 13; i++) begin
            prog(INSTR_ARITH, op_tab[i], 8'h00, val_tab[i]);
            exp_acc = alu(exp_acc, val_tab[i], op_tab[i]);
            check(accumulator, exp_acc, "arith result");
            check({31'h0, prog_error}, {31'h0, op_tab[i] > 8'h09}, "bad op flag");
        end
        prog(INSTR_ARITH, 8'h09, 8'h00, 32'h3E8);
        for (int i = 0; i < 4; i++) begin
            prog(INSTR_COMPARE, 8'h5A, 8'hC3, cmp_val[i]);
            check({flag_zero, flag_greater, flag_less}, cmp_exp[i], "compare flags");
            check(accumulator, 32'h3E8, "compare kept acc");
        end
        for (int p = 0; p < 4; p++) begin
            prog(INSTR_READ_IO, p[7:0], BANK_DIGITAL, 32'h5555AAAA);
            check(accumulator, {31'h0, pins[p]}, "digital load");
            prog(INSTR_READ_IO, p[7:0], BANK_ANALOG, 32'h0);
            check(accumulator, {20'h0, smp[p]}, "analog load");
        end
        for (int p = 0; p < 4; p++) begin
            cmd(8'h01, INSTR_READ_IO, p[7:0], BANK_ANALOG, 32'h0, p % 2, STATUS_OK, {20'h0, smp[p]});
            cmd(8'h01, INSTR_READ_IO, p[7:0], BANK_DIGITAL, 32'h0, 0, STATUS_OK, {31'h0, pins[p]});
        end
        check(accumulator, {20'h0, smp[3]}, "direct read kept acc");
        cmd(8'h01, INSTR_SET_OUTPUT, 8'h00, BANK_OUTPUTS, 32'h1, 0, STATUS_OK, 32'h0);
        check({31'h0, general_output_zero}, 32'h1, "output high");
        cmd(8'h01, INSTR_READ_IO, 8'h00, BANK_OUTPUTS, 32'h0, 0, STATUS_OK, 32'h1);
        cmd(8'h01, INSTR_SET_OUTPUT, 8'h00, BANK_OUTPUTS, 32'h0, 1, STATUS_OK, 32'h0);
        cmd(8'h01, INSTR_READ_IO, 8'h00, BANK_OUTPUTS, 32'h0, 1, STATUS_OK, 32'h0);
        cmd(8'h01, INSTR_ARITH, 8'h09, 8'h00, 32'h3, 0, STATUS_OK, 32'h3);
        cmd(8'h01, INSTR_ARITH, 8'h02, 8'h00, 32'hFFFFEC78, 0, STATUS_OK, 32'hFFFFEC78);
        check(accumulator, 32'hFFFFC568, "direct multiply");
        cmd(8'h01, INSTR_COMPARE, 8'h11, 8'h22, 32'hFFFFC568, 0, STATUS_OK, 32'hFFFFC568);
        check({flag_zero, flag_greater, flag_less}, 3'b100, "direct compare");
        cmd(8'h01, INSTR_READ_IO, 8'h00, BANK_ANALOG, 32'h0, 2, STATUS_OK, 32'h0);
        cmd(8'h03, INSTR_READ_IO, 8'h00, BANK_ANALOG, 32'h0, 0, STATUS_OK, 32'h0);
        cmd(8'h01, INSTR_READ_IO, 8'h00, 8'h03, 32'h0, 0, STATUS_BAD_VALUE, 32'h0);
        cmd(8'h01, 8'h2A, 8'h00, 8'h00, 32'h0, 0, STATUS_BAD_CMD, 32'h0);
        conclude();
    end
endmodule : io_read_accumulator_cmds_tb
`default_nettype wire
